/* File: include/window_regs_pkg.sv */
package window_regs_pkg;
   // register byte offsets
   localparam logic [7:0] ofs_mem_win = 8'h20;
   localparam logic [7:0] ofs_pref_win = 8'h24;
   localparam logic [7:0] ofs_pref_base_hi = 8'h28;
   localparam logic [7:0] ofs_pref_limit_hi = 8'h2c;
   localparam logic [7:0] ofs_io_hi = 8'h30;
   localparam logic [7:0] ofs_cap_ptr = 8'h34;
   localparam logic [7:0] ofs_rom_base = 8'h38;
   localparam logic [7:0] ofs_irq = 8'h3c;

   // field positions inside the 32-bit word
   localparam int base_lsb = 4;
   localparam int base_msb = 15;
   localparam int limit_lsb = 20;
   localparam int limit_msb = 31;
   localparam int low_half_msb = 15;
   localparam int high_half_lsb = 16;
   localparam int irq_line_msb = 7;
   localparam int irq_pin_lsb = 8;
   localparam int irq_pin_msb = 15;
   localparam int win_width = 12;
   localparam int win_gran_lsb = 20;

   // reset values
   localparam logic [11:0] win_reset = 12'h000;
   localparam logic [31:0] word_reset = 32'h0000_0000;
   localparam logic [15:0] half_reset = 16'h0000;
   localparam logic [7:0] irq_line_reset = 8'h00;

   // read-only constants
   localparam logic [3:0] addr_type_32 = 4'h0;
   localparam logic [3:0] addr_type_64 = 4'h1;
   localparam logic [7:0] cap_ptr_normal = 8'h80;
   localparam logic [7:0] cap_ptr_legacy = 8'h90;
   localparam logic [7:0] irq_pin_a = 8'h01;
   localparam logic [31:0] rom_base_value = 32'h0000_0000;
   localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage

/* File: hw/bridge_window_config_regs.sv */
// Overview of operation
// (R1) memory window base is bits 15:4 at 20h, reset zero; bits 3:0 read zero
// (R2) memory window limit is bits 31:20 at 20h, reset zero; bits 19:16 read zero
// (R3) prefetch window base is bits 15:4 at 24h, reset zero; bits 3:0 read 0001
// (R4) prefetch window limit is bits 31:20 at 24h, reset zero; bits 19:16 read 0001
// (R5) prefetch base upper 32 address bits, writable word at 28h, reset zero
// (R6) prefetch limit upper 32 address bits, writable word at 2ch, reset zero
// (R7) i/o base upper 16 bits in bits 15:0 at 30h, writable, reset zero
// (R8) i/o limit upper 16 bits in bits 31:16 at 30h, writable, reset zero
// (R9) capability pointer at 34h reads 80h, or 90h in legacy mode; upper bits zero
// (R10) option rom base at 38h always reads zero; writes are ignored
// (R11) interrupt routing number in bits 7:0 at 3ch, writable, reset 00h
// (R12) interrupt pin field, bits 15:8 at 3ch, reads constant 01h
// (R13) forwarding hit uses 1 MB granularity, limit low bits taken as ones
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module bridge_window_config_regs #(
   parameter int addr_width = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [addr_width-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic legacy_mode,
   input wire logic [63:0] fwd_addr,
   input wire logic fwd_valid,
   output logic mem_hit,
   output logic pref_hit
);

   logic [11:0] mem_base;
   logic [11:0] mem_limit;
   logic [11:0] pref_base;
   logic [11:0] pref_limit;
   logic [31:0] pref_base_hi;
   logic [31:0] pref_limit_hi;
   logic [15:0] io_base_hi;
   logic [15:0] io_limit_hi;
   logic [7:0] irq_line;
   logic legacy_meta;
   logic legacy_sync;

   // address decode
   wire logic [7:0] ofs = addr[7:0];
   wire logic sel_mem = (ofs == window_regs_pkg::ofs_mem_win);
   wire logic sel_pref = (ofs == window_regs_pkg::ofs_pref_win);
   wire logic sel_pbh = (ofs == window_regs_pkg::ofs_pref_base_hi);
   wire logic sel_plh = (ofs == window_regs_pkg::ofs_pref_limit_hi);
   wire logic sel_io = (ofs == window_regs_pkg::ofs_io_hi);
   wire logic sel_cap = (ofs == window_regs_pkg::ofs_cap_ptr);
   wire logic sel_rom = (ofs == window_regs_pkg::ofs_rom_base);
   wire logic sel_irq = (ofs == window_regs_pkg::ofs_irq);
   wire logic addr_hi_zero = (addr_width <= 8) ? 1'b1 : (addr >> 8) == '0;

   wire logic wr_mem = wr && addr_hi_zero && sel_mem;
   wire logic wr_pref = wr && addr_hi_zero && sel_pref;
   wire logic wr_pbh = wr && addr_hi_zero && sel_pbh;
   wire logic wr_plh = wr && addr_hi_zero && sel_plh;
   wire logic wr_io = wr && addr_hi_zero && sel_io;
   wire logic wr_irq = wr && addr_hi_zero && sel_irq;

   wire logic [11:0] wr_base_field =
      wdata[window_regs_pkg::base_msb:window_regs_pkg::base_lsb];
   wire logic [11:0] wr_limit_field =
      wdata[window_regs_pkg::limit_msb:window_regs_pkg::limit_lsb];
   wire logic [15:0] wr_low_half = wdata[window_regs_pkg::low_half_msb:0];
   wire logic [15:0] wr_high_half = wdata[31:window_regs_pkg::high_half_lsb];

   // legacy strap crosses in from a pin
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         legacy_meta <= 1'b0;
         legacy_sync <= 1'b0;
      end
      else
      begin
         legacy_meta <= legacy_mode;
         legacy_sync <= legacy_meta;
      end
   end

   // (R1) memory base store
   // (R2) memory limit store
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_base <= window_regs_pkg::win_reset;
         mem_limit <= window_regs_pkg::win_reset;
      end
      else if (wr_mem)
      begin
         mem_base <= wr_base_field;
         mem_limit <= wr_limit_field;
      end
   end

   // (R3) prefetch base store
   // (R4) prefetch limit store
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pref_base <= window_regs_pkg::win_reset;
         pref_limit <= window_regs_pkg::win_reset;
      end
      else if (wr_pref)
      begin
         pref_base <= wr_base_field;
         pref_limit <= wr_limit_field;
      end
   end

   // (R5) base upper word
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pref_base_hi <= window_regs_pkg::word_reset;
      else if (wr_pbh)
         pref_base_hi <= wdata;
   end

   // (R6) limit upper word
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pref_limit_hi <= window_regs_pkg::word_reset;
      else if (wr_plh)
         pref_limit_hi <= wdata;
   end

   // (R7) i/o base upper
   // (R8) i/o limit upper
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         io_base_hi <= window_regs_pkg::half_reset;
         io_limit_hi <= window_regs_pkg::half_reset;
      end
      else if (wr_io)
      begin
         io_base_hi <= wr_low_half;
         io_limit_hi <= wr_high_half;
      end
   end

   // (R11) routing number store
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         irq_line <= window_regs_pkg::irq_line_reset;
      else if (wr_irq)
         irq_line <= wdata[window_regs_pkg::irq_line_msb:0];
   end

   // read words; the upper half at 3ch belongs to bridge control, kept elsewhere
   // (R1) reserved low nibble
   // (R2) reserved nibble zero
   wire logic [31:0] rd_mem_word = {mem_limit, window_regs_pkg::addr_type_32,
                                    mem_base, window_regs_pkg::addr_type_32};
   // (R3) base type nibble
   // (R4) limit type nibble
   wire logic [31:0] rd_pref_word = {pref_limit, window_regs_pkg::addr_type_64,
                                     pref_base, window_regs_pkg::addr_type_64};
   wire logic [31:0] rd_io_word = {io_limit_hi, io_base_hi};
   // (R9) legacy pointer select
   wire logic [7:0] cap_value = legacy_sync ? window_regs_pkg::cap_ptr_legacy
                                            : window_regs_pkg::cap_ptr_normal;
   wire logic [31:0] rd_cap_word = {24'h00_0000, cap_value};
   // (R12) fixed pin code
   wire logic [31:0] rd_irq_word = {16'h0000, window_regs_pkg::irq_pin_a, irq_line};

   // (R10) rom base zero
   wire logic [31:0] read_mux =
      !addr_hi_zero ? window_regs_pkg::read_zero :
      sel_mem ? rd_mem_word :
      sel_pref ? rd_pref_word :
      sel_pbh ? pref_base_hi :
      sel_plh ? pref_limit_hi :
      sel_io ? rd_io_word :
      sel_cap ? rd_cap_word :
      sel_rom ? window_regs_pkg::rom_base_value :
      sel_irq ? rd_irq_word :
      window_regs_pkg::read_zero;

   // read data only valid the cycle after the strobe
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= window_regs_pkg::read_zero;
      else if (rd)
         rdata <= read_mux;
      else
         rdata <= window_regs_pkg::read_zero;
   end

   // (R13) 1 MB window compare
   wire logic [11:0] addr_mb = fwd_addr[31:window_regs_pkg::win_gran_lsb];
   wire logic [43:0] addr_mb64 = fwd_addr[63:window_regs_pkg::win_gran_lsb];
   wire logic [43:0] pref_lo64 = {pref_base_hi, pref_base};
   wire logic [43:0] pref_hi64 = {pref_limit_hi, pref_limit};
   // limit compares on the megabyte index, so its low 20 bits act as all ones
   wire logic mem_in = (fwd_addr[63:32] == 32'h0000_0000) &&
                       (addr_mb >= mem_base) && (addr_mb <= mem_limit);
   wire logic pref_in = (addr_mb64 >= pref_lo64) && (addr_mb64 <= pref_hi64);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_hit <= 1'b0;
         pref_hit <= 1'b0;
      end
      else
      begin
         mem_hit <= fwd_valid && mem_in;
         pref_hit <= fwd_valid && pref_in;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   wire logic rd_ok = rd && addr_hi_zero;

   mem_base_wr_a: assert property ( // (R1)
      wr_mem |=> mem_base == $past(wdata[15:4]) && rd_mem_word[3:0] == 4'h0)
      else $error("memory base not stored");

   mem_limit_wr_a: assert property ( // (R2)
      wr_mem ##1 (rd_ok && sel_mem) |=>
         rdata[31:20] == $past(wdata[31:20], 2) && rdata[19:16] == 4'h0)
      else $error("memory limit readback wrong");

   pref_base_rd_a: assert property ( // (R3)
      rd_ok && sel_pref |=> rdata[3:0] == 4'h1 && rdata[15:4] == $past(pref_base))
      else $error("prefetch base readback wrong");

   pref_limit_rd_a: assert property ( // (R4)
      wr_pref |=> pref_limit == $past(wdata[31:20]) && rd_pref_word[19:16] == 4'h1)
      else $error("prefetch limit readback wrong");

   base_hi_wr_a: assert property ( // (R5)
      wr_pbh ##1 (rd_ok && sel_pbh) |=> rdata == $past(wdata, 2))
      else $error("base upper word lost");

   limit_hi_wr_a: assert property ( // (R6)
      wr_plh ##1 (rd_ok && sel_plh) |=> rdata == $past(wdata, 2))
      else $error("limit upper word lost");

   io_base_wr_a: assert property ( // (R7)
      wr_io |=> io_base_hi == $past(wdata[15:0]))
      else $error("io base upper not stored");

   io_limit_wr_a: assert property ( // (R8)
      wr_io ##1 (rd_ok && sel_io) |=> rdata[31:16] == $past(wdata[31:16], 2))
      else $error("io limit upper readback wrong");

   cap_ptr_rd_a: assert property ( // (R9)
      rd_ok && sel_cap |=>
         rdata == ($past(legacy_sync) ? 32'h0000_0090 : 32'h0000_0080))
      else $error("capability pointer wrong");

   rom_base_rd_a: assert property ( // (R10)
      rd_ok && sel_rom |=> rdata == 32'h0000_0000)
      else $error("rom base not zero");

   irq_line_wr_a: assert property ( // (R11)
      wr_irq ##1 (rd_ok && sel_irq) |=> rdata[7:0] == $past(wdata[7:0], 2))
      else $error("routing number readback wrong");

   irq_pin_rd_a: assert property ( // (R12)
      rd_ok && sel_irq |=> rdata[15:8] == 8'h01 && rdata[31:16] == 16'h0000)
      else $error("interrupt pin field wrong");

   mem_hit_a: assert property ( // (R13)
      fwd_valid && fwd_addr[63:32] == 32'h0000_0000 &&
      fwd_addr[31:20] >= mem_base && fwd_addr[31:20] <= mem_limit |=> mem_hit)
      else $error("memory window hit missed");

   pref_miss_a: assert property ( // (R13)
      !fwd_valid |=> !mem_hit && !pref_hit)
      else $error("hit without a request");

   // fields keep their value between writes
   mem_base_hold_a: assert property ( // (R1)
      !wr_mem |=> $stable(mem_base))
      else $error("memory base changed without a write");

   mem_limit_hold_a: assert property ( // (R2)
      !wr_mem |=> $stable(mem_limit))
      else $error("memory limit changed without a write");

   pref_base_hold_a: assert property ( // (R3)
      !wr_pref |=> $stable(pref_base))
      else $error("prefetch base changed without a write");

   pref_limit_hold_a: assert property ( // (R4)
      !wr_pref |=> $stable(pref_limit))
      else $error("prefetch limit changed without a write");

   base_hi_hold_a: assert property ( // (R5)
      !wr_pbh |=> $stable(pref_base_hi))
      else $error("base upper word changed without a write");

   limit_hi_hold_a: assert property ( // (R6)
      !wr_plh |=> $stable(pref_limit_hi))
      else $error("limit upper word changed without a write");

   io_base_hold_a: assert property ( // (R7)
      !wr_io |=> $stable(io_base_hi))
      else $error("io base upper changed without a write");

   io_limit_hold_a: assert property ( // (R8)
      !wr_io |=> $stable(io_limit_hi))
      else $error("io limit upper changed without a write");

   irq_line_hold_a: assert property ( // (R11)
      !wr_irq |=> $stable(irq_line))
      else $error("routing number changed without a write");

   // read words carry the stored fields
   mem_word_rd_a: assert property ( // (R1)
      rd_ok && sel_mem |=> rdata[15:4] == $past(mem_base) && rdata[3:0] == 4'h0)
      else $error("memory base readback wrong");

   mem_limit_rd_a: assert property ( // (R2)
      rd_ok && sel_mem |=> rdata[31:20] == $past(mem_limit) && rdata[19:16] == 4'h0)
      else $error("memory limit field readback wrong");

   pref_type_rd_a: assert property ( // (R4)
      rd_ok && sel_pref |=> rdata[31:20] == $past(pref_limit) && rdata[19:16] == 4'h1)
      else $error("prefetch limit field readback wrong");

   base_hi_rd_a: assert property ( // (R5)
      rd_ok && sel_pbh |=> rdata == $past(pref_base_hi))
      else $error("base upper word readback wrong");

   limit_hi_rd_a: assert property ( // (R6)
      rd_ok && sel_plh |=> rdata == $past(pref_limit_hi))
      else $error("limit upper word readback wrong");

   io_word_rd_a: assert property ( // (R7)
      rd_ok && sel_io |=> rdata == {$past(io_limit_hi), $past(io_base_hi)})
      else $error("io word readback wrong");

   irq_word_rd_a: assert property ( // (R11)
      rd_ok && sel_irq |=> rdata[7:0] == $past(irq_line))
      else $error("routing number field readback wrong");

   // prefetch window hit and memory window miss
   pref_hit_a: assert property ( // (R13)
      fwd_valid && fwd_addr[63:20] >= {pref_base_hi, pref_base} &&
      fwd_addr[63:20] <= {pref_limit_hi, pref_limit} |=> pref_hit)
      else $error("prefetch window hit missed");

   mem_miss_a: assert property ( // (R13)
      fwd_valid && fwd_addr[63:32] != 32'h0000_0000 |=> !mem_hit)
      else $error("memory hit above 4 GB");

   legacy_read_c: cover property (rd_ok && sel_cap && legacy_sync);
   mem_hit_c: cover property (wr_mem ##[1:20] mem_hit);
   pref_hit_c: cover property (wr_plh ##[1:20] pref_hit);
   back_to_back_c: cover property (wr_irq ##1 rd_ok && sel_irq);
   rom_write_c: cover property (wr && addr_hi_zero && sel_rom);

endmodule

/* File: tb/test_bridge_window_config_regs.sv */
`timescale 1ns/10ps
module test_bridge_window_config_regs;
   logic core_clk;
   logic nrst;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic legacy_mode;
   logic [63:0] fwd_addr;
   logic fwd_valid;
   logic mem_hit;
   logic pref_hit;
   int n_errors = 0;
   int checks_done = 0;
   logic [7:0] offs [8];
   logic [31:0] wmask [8];
   logic [31:0] rofix [8];

   bridge_window_config_regs #(.addr_width(8)) dut_u (
      .core_clk(core_clk),
      .nrst(nrst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .legacy_mode(legacy_mode),
      .fwd_addr(fwd_addr),
      .fwd_valid(fwd_valid),
      .mem_hit(mem_hit),
      .pref_hit(pref_hit)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic conclude;
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   // rdata stands only in the cycle after the read edge
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk32(rdata, e);
   endtask

   task automatic fwd(input logic [63:0] a, input logic em, input logic ep);
      @(posedge core_clk);
      fwd_valid <= 1'b1;
      fwd_addr <= a;
      @(posedge core_clk);
      fwd_valid <= 1'b0;
      #1;
      chk1(mem_hit, em);
      chk1(pref_hit, ep);
   endtask

   task automatic do_reset;
      nrst <= 1'b0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
   endtask

   task automatic reset_vals;
      for (int i = 0; i < 8; i++)
         rd_chk(offs[i], rofix[i]);
   endtask

   initial
   begin
      #2000000;
      n_errors++;
      conclude;
   end

   initial
   begin
      nrst = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      legacy_mode = 1'b0;
      fwd_addr = 64'h0;
      fwd_valid = 1'b0;
      offs = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
      wmask = '{32'hfff0_fff0, 32'hfff0_fff0, 32'hffff_ffff, 32'hffff_ffff,
                32'hffff_ffff, 32'h0, 32'h0, 32'h0000_00ff};
      rofix = '{32'h0, 32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0000_0080,
                32'h0, 32'h0000_0100};
      do_reset;
      reset_vals;
      foreach (wmask[k])
      begin
         reg_wr(offs[k], 32'hffff_ffff);
         rd_chk(offs[k], wmask[k] | rofix[k]);
         reg_wr(offs[k], 32'h5a3c_c3a5);
         rd_chk(offs[k], (32'h5a3c_c3a5 & wmask[k]) | rofix[k]);
      end
      // unmapped place reads zero, then rdata drops back
      reg_wr(8'h40, 32'hffff_ffff);
      rd_chk(8'h40, 32'h0);
      rd_chk(8'h34, 32'h0000_0080);
      @(posedge core_clk);
      #1;
      chk32(rdata, 32'h0);
      // read straight after write, no gap
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= 8'h3c;
      wdata <= 32'hffff_ff3e;
      @(posedge core_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk32(rdata, 32'h0000_013e);
      // legacy strap passes two sync stages, so the next read still sees 80h
      @(posedge core_clk);
      legacy_mode <= 1'b1;
      rd_chk(8'h34, 32'h0000_0080);
      repeat (3) @(posedge core_clk);
      rd_chk(8'h34, 32'h0000_0090);
      @(posedge core_clk);
      legacy_mode <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd_chk(8'h34, 32'h0000_0080);
      // window edges at 1 MB steps
      reg_wr(8'h20, 32'h0020_0010);
      reg_wr(8'h24, 32'hfff0_0000);
      reg_wr(8'h28, 32'h0000_0001);
      reg_wr(8'h2c, 32'h0000_0001);
      fwd(64'h0000_0000_0010_0000, 1'b1, 1'b0);
      fwd(64'h0000_0000_002f_ffff, 1'b1, 1'b0);
      fwd(64'h0000_0000_0030_0000, 1'b0, 1'b0);
      fwd(64'h0000_0000_000f_ffff, 1'b0, 1'b0);
      fwd(64'h0000_0001_0010_0000, 1'b0, 1'b1);
      fwd(64'h0000_0001_ffff_ffff, 1'b0, 1'b1);
      fwd(64'h0000_0000_ffff_ffff, 1'b0, 1'b0);
      fwd(64'h0000_0002_0000_0000, 1'b0, 1'b0);
      @(posedge core_clk);
      #1;
      chk1(mem_hit | pref_hit, 1'b0);
      // second reset in mid-run clears every field
      @(posedge core_clk);
      do_reset;
      reset_vals;
      conclude;
   end
endmodule
